// >>> src/period_match_timer.sv
// Purpose: 8-bit period match timer with prescaler and postscaler
// Assumes: AXI4-Lite slave, aclk is the system oscillator
// Notes: Interrupt request is a registered level output
//
// How it works
// - Instruction clock is aclk/4, through prescaler
// - Prescale codes: 00 by1, 01 by4, 1x by16
// - Count compared to period continuously, rising
// - Match: count to zero, postscaler advances
// - Postscaler output sets match interrupt flag
// - Postscale field N divides matches by N+1
// - Count, period read/write; reset 00h, FFh
// - Run bit one counts, zero halts
// - Count or control write clears scalers
// - Control write keeps count value
// - Control bit 7 reads zero; resets zero
`timescale 1ns/10ps
module period_match_timer
  import period_timer_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic aw_held;          // Write address captured
    logic [3:0] aw_addr;
    logic w_held;           // Write data captured
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [1:0] insn_div;   // Fosc/4 phase
    logic [3:0] pre_cnt;    // Prescaler counter
    logic [3:0] post_cnt;   // Postscaler counter
    logic match_pending;    // Match seen, reload on next increment
    control_s control;
    logic [7:0] period_value;
    logic [7:0] count_value;
    irq_s irqr;
    logic irq;
  } state_s;

  state_s r;       // Registered state
  state_s next_r;  // Next state

  // Prescale terminal count for a select code
  function automatic logic [3:0] pre_tc(input logic [1:0] sel);
    if (sel[1]) begin
      pre_tc = PRE_TC_16;
    end else if (sel[0]) begin
      pre_tc = PRE_TC_4;
    end else begin
      pre_tc = PRE_TC_1;
    end
  endfunction

  // Read data for a register offset
  function automatic logic [31:0] reg_read(input state_s s, input logic [3:0] a);
    unique case (a)
      OFF_CONTROL: reg_read = {25'h000_0000, s.control};
      OFF_PERIOD: reg_read = {24'h00_0000, s.period_value};
      OFF_COUNT: reg_read = {24'h00_0000, s.count_value};
      OFF_IRQ: reg_read = {28'h000_0000, s.irqr};
      default: reg_read = 32'h0000_0000;
    endcase
  endfunction

  // Known offset check
  function automatic logic mapped(input logic [3:0] a);
    mapped = (a == OFF_CONTROL) || (a == OFF_PERIOD) || (a == OFF_COUNT) || (a == OFF_IRQ);
  endfunction

  // Write intent, decoded in the combinational process
  logic do_write;
  logic wr_control;
  logic wr_period;
  logic wr_count;
  logic wr_irq;
  logic insn_tick;     // One-cycle instruction clock enable
  logic pre_tick;      // Prescaler output pulse
  logic post_tick;     // Postscaler output pulse
  logic is_match;

  // ****************************************
  // Next state logic
  // ****************************************
  always_comb begin
    next_r = r;

    // Write channel capture, either order
    if (s_axi_awvalid && s_axi_awready) begin
      next_r.aw_held = 1'b1;
      next_r.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_r.w_held = 1'b1;
      next_r.w_data = s_axi_wdata;
      next_r.w_strb = s_axi_wstrb;
    end

    // Commit write once both halves are held and response slot is free
    do_write = r.aw_held && r.w_held && !r.bvalid;
    wr_control = do_write && (r.aw_addr == OFF_CONTROL) && r.w_strb[0];
    wr_period = do_write && (r.aw_addr == OFF_PERIOD) && r.w_strb[0];
    wr_count = do_write && (r.aw_addr == OFF_COUNT) && r.w_strb[0];
    wr_irq = do_write && (r.aw_addr == OFF_IRQ) && r.w_strb[0];
    if (do_write) begin
      next_r.aw_held = 1'b0;
      next_r.w_held = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp = mapped(r.aw_addr) ? RESP_OKAY : RESP_SLVERR;
    end else if (r.bvalid && s_axi_bready) begin
      next_r.bvalid = 1'b0;
    end

    // Read channel
    if (s_axi_arvalid && s_axi_arready) begin
      next_r.rvalid = 1'b1;
      next_r.rdata = reg_read(r, s_axi_araddr);
      next_r.rresp = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (r.rvalid && s_axi_rready) begin
      next_r.rvalid = 1'b0;
    end

    // Instruction clock divider runs free from aclk
    insn_tick = (r.insn_div == INSN_DIV);
    next_r.insn_div = r.insn_div + 2'h1;

    // Prescaler only advances while running
    pre_tick = 1'b0;
    if (insn_tick && r.control.run_enable) begin
      if (r.pre_cnt >= pre_tc(r.control.prescale_select)) begin
        next_r.pre_cnt = 4'h0;
        pre_tick = 1'b1;
      end else begin
        next_r.pre_cnt = r.pre_cnt + 4'h1;
      end
    end

    // Continuous compare of count against period
    is_match = (r.count_value == r.period_value);
    post_tick = 1'b0;
    if (pre_tick) begin
      if (r.match_pending) begin
        next_r.count_value = COUNT_RESET;
        next_r.match_pending = 1'b0;
      end else begin
        next_r.count_value = r.count_value + 8'h01;
      end
      // A fresh match seen at this increment advances the postscaler
      if (!r.match_pending && (r.count_value + 8'h01) == r.period_value) begin
        next_r.match_pending = 1'b1;
        if (r.post_cnt >= r.control.postscale_select) begin
          next_r.post_cnt = 4'h0;
          post_tick = 1'b1;
        end else begin
          next_r.post_cnt = r.post_cnt + 4'h1;
        end
      end
    end

    // Software writes; these override the counting above
    if (wr_control) begin
      next_r.control = control_s'(r.w_data[6:0] & CONTROL_MASK);
      next_r.pre_cnt = 4'h0;
      next_r.post_cnt = 4'h0;
      next_r.count_value = r.count_value;
      next_r.match_pending = is_match;
    end
    if (wr_period) begin
      next_r.period_value = r.w_data[7:0];
      next_r.match_pending = (r.count_value == r.w_data[7:0]);
    end
    if (wr_count) begin
      next_r.count_value = r.w_data[7:0];
      next_r.pre_cnt = 4'h0;
      next_r.post_cnt = 4'h0;
      next_r.match_pending = (r.w_data[7:0] == r.period_value);
    end

    // Interrupt register: software writes; hardware set wins over clear
    if (wr_irq) begin
      next_r.irqr = irq_s'(r.w_data[3:0]);
    end
    if (post_tick) begin
      next_r.irqr.match_interrupt_flag = 1'b1;
    end

    // Request only with all three enables
    next_r.irq = next_r.irqr.match_interrupt_flag && next_r.irqr.match_interrupt_enable &&
                 next_r.irqr.peripheral_interrupt_enable && next_r.irqr.global_interrupt_enable;
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
      r.control <= control_s'(CONTROL_RESET[6:0]);
      r.period_value <= PERIOD_RESET;
      r.count_value <= COUNT_RESET;
      r.pre_cnt <= 4'h0;
      r.post_cnt <= 4'h0;
    end else begin
      r <= next_r;
    end
  end

  // ****************************************
  // Outputs, all from flip-flops
  // ****************************************
  assign s_axi_awready = !r.aw_held;
  assign s_axi_wready = !r.w_held;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp = r.bresp;
  assign s_axi_arready = !r.rvalid;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rdata = r.rdata;
  assign s_axi_rresp = r.rresp;
  assign irq = r.irq;

endmodule

// >>> src/period_timer_pkg.sv
// Purpose: Shared constants and types for the period match timer
// Assumes: 32-bit AXI4-Lite register access, one word per register
// Notes: Offsets and interrupt register layout are local choices
package period_timer_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [3:0] OFF_CONTROL = 4'h0;   // timer_control
  localparam logic [3:0] OFF_PERIOD = 4'h4;    // period_value
  localparam logic [3:0] OFF_COUNT = 4'h8;     // count_value
  localparam logic [3:0] OFF_IRQ = 4'hC;       // flag and enables

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int RUN_BIT = 2;                 // run_enable
  localparam int PRE_LSB = 0;                 // prescale_select low bit
  localparam int POST_LSB = 3;                // postscale_select low bit
  localparam int FLAG_BIT = 0;                // match_interrupt_flag
  localparam int MIE_BIT = 1;                 // match_interrupt_enable
  localparam int PIE_BIT = 2;                 // peripheral_interrupt_enable
  localparam int GIE_BIT = 3;                 // global_interrupt_enable
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] PERIOD_RESET = 8'hFF;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [6:0] CONTROL_MASK = 7'h7F; // Bit 7 unimplemented

  // ****************************************
  // Counts
  // ****************************************
  localparam logic [1:0] INSN_DIV = 2'h3;     // Fosc/4 divider terminal count
  localparam logic [3:0] PRE_TC_1 = 4'h0;
  localparam logic [3:0] PRE_TC_4 = 4'h3;
  localparam logic [3:0] PRE_TC_16 = 4'hF;

  // AXI response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Control register fields
  typedef struct packed {
    logic [3:0] postscale_select;
    logic run_enable;
    logic [1:0] prescale_select;
  } control_s;

  // Interrupt register fields
  typedef struct packed {
    logic global_interrupt_enable;
    logic peripheral_interrupt_enable;
    logic match_interrupt_enable;
    logic match_interrupt_flag;
  } irq_s;

endpackage

// >>> test/period_match_timer_monitor.sv
// Purpose: Port checker for period_match_timer
// Assumes: Only the top module ports are visible
// Notes: Bound to the design at the foot of this file
`timescale 1ns/10ps
module period_match_timer_monitor
  import period_timer_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic irq
);
  // ****************************************
  // Bus and reset properties
  // ****************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_ctl_rd;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == OFF_CONTROL;
  endsequence
  sequence s_wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid;
  endsequence
  property p_ar_free; s_axi_arready == !s_axi_rvalid; endproperty
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  property p_r_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  // Both halves are held one cycle before the commit, so the answer comes two edges on
  property p_b_lat; s_wr_both |-> ##2 s_axi_bvalid; endproperty
  property p_upper; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000; endproperty
  property p_ctl_msb; s_ctl_rd |=> s_axi_rdata[7] == 1'b0; endproperty
  // Reset itself is the trigger, so this one is never disabled
  property p_reset; disable iff (1'b0) !aresetn |=> !irq && !s_axi_bvalid && !s_axi_rvalid; endproperty
  a_ar_free: assert property (p_ar_free) else $error("arready not inverse of rvalid");
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped or changed");
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped or changed");
  a_r_lat: assert property (p_r_lat) else $error("read answer late");
  a_b_lat: assert property (p_b_lat) else $error("write answer late");
  a_upper: assert property (p_upper) else $error("upper read bits set");
  a_ctl_msb: assert property (p_ctl_msb) else $error("control bit 7 read as one");
  a_reset: assert property (p_reset) else $error("outputs active after reset");
endmodule
bind period_match_timer period_match_timer_monitor period_match_timer_monitor_i (.aclk(aclk),
  .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq(irq));

// >>> test/tb_period_match_timer.sv
// Purpose: Register-level bench for period_match_timer
// Assumes: aclk 250 MHz, sync active-low reset
// Notes: Timer rates checked by elapsed cycles
`timescale 1ns/10ps
module tb_period_match_timer;
  import period_timer_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, irq;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rd;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int mismatches = 0, n_checks = 0, cyc = 0, t0, t1, posts[3] = '{0, 3, 15};
  period_match_timer period_match_timer_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .irq(irq));
  // ****************************************
  // Clock, cycle count and tasks
  // ****************************************
  initial forever #2 aclk = ~aclk;
  always @(posedge aclk) cyc <= cyc + 1;
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Leading edge keeps two calls from driving one signal in one step
  // Handshakes are judged at the falling edge, so the value seen is the one the next rising edge samples
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic aw, w, ta, tw;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    aw = 1'b0;
    w = 1'b0;
    while (!(aw && w)) begin
      @(negedge aclk);
      ta = (s_axi_awready === 1'b1) && s_axi_awvalid;
      tw = (s_axi_wready === 1'b1) && s_axi_wvalid;
      @(posedge aclk);
      if (ta) begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (tw) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
    @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rdr(input logic [3:0] a, output logic [31:0] d);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge aclk); while (s_axi_arready !== 1'b1);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask
  task automatic rchk(input string what, input logic [3:0] a, input logic [31:0] exp);
    rdr(a, rd);
    chk(what, exp, rd);
  endtask
  // Bounded wait for the request; returns the cycle it was seen
  task automatic wirq(output int t);
    t = cyc + 2000;
    while (irq !== 1'b1 && cyc < t) @(posedge aclk);
    t = cyc;
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    #100000;
    mismatches++;
    give_verdict;
  end
  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rchk("control", OFF_CONTROL, 32'h0000_0000);
    rchk("period", OFF_PERIOD, 32'h0000_00FF);
    rchk("count", OFF_COUNT, 32'h0000_0000);
    rchk("irq reg", OFF_IRQ, 32'h0000_0000);
    wr(OFF_CONTROL, 8'hFB);
    rchk("control", OFF_CONTROL, 32'h0000_007B);
    wr(OFF_PERIOD, 8'hA5);
    rchk("period", OFF_PERIOD, 32'h0000_00A5);
    wr(OFF_COUNT, 8'h5A);
    repeat (200) @(posedge aclk);
    rchk("halted count", OFF_COUNT, 32'h0000_005A);
    wr(OFF_CONTROL, 8'h00);
    rchk("count kept", OFF_COUNT, 32'h0000_005A);
    // Each prescale code runs 640 cycles; two steps of slack for write skew
    wr(OFF_PERIOD, 8'hFF);
    for (int c = 0; c < 4; c++) begin
      t0 = 640 / (4 * (c == 0 ? 1 : (c == 1 ? 4 : 16)));
      wr(OFF_COUNT, 8'h00);
      wr(OFF_CONTROL, 8'(4 + c));
      repeat (640) @(posedge aclk);
      wr(OFF_CONTROL, 8'(c));
      rdr(OFF_COUNT, rd);
      chk("prescale", 32'h0000_0001, 32'(rd <= t0 + 2 && rd + 2 >= t0));
    end
    // Period 3 at 1:1 gives a match every 16 cycles
    wr(OFF_PERIOD, 8'h03);
    foreach (posts[i]) begin
      wr(OFF_CONTROL, 8'h00);
      wr(OFF_IRQ, 8'h0E);
      wr(OFF_CONTROL, 8'(posts[i] * 8 + 4));
      wirq(t0);
      wr(OFF_IRQ, 8'h0E);
      rdr(OFF_COUNT, rd);
      chk("count bound", 32'h0000_0001, 32'(rd <= 3));
      wirq(t1);
      chk("match interval", 32'(16 * (posts[i] + 1)), 32'(t1 - t0));
    end
    wr(OFF_CONTROL, 8'h00);
    wr(OFF_IRQ, 8'h06);
    wr(OFF_CONTROL, 8'h04);
    repeat (100) @(posedge aclk);
    rchk("flag masked", OFF_IRQ, 32'h0000_0007);
    chk("irq masked", 32'h0000_0000, {31'h0000_0000, irq});
    wr(OFF_IRQ, 8'h0F);
    repeat (2) @(posedge aclk);
    chk("irq enabled", 32'h0000_0001, {31'h0000_0000, irq});
    give_verdict;
  end
endmodule
